// file: hdl/drive_ctrl_pkg.sv
// package: register map, field positions, codes and carrier types of the drive control block
package drive_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] PHASE_OFS     = 8'h00;
	localparam logic [7:0] CYCLE_OFS     = 8'h04;
	localparam logic [7:0] SD_CTRL_OFS   = 8'h08;
	localparam logic [7:0] ENTER_PL_OFS  = 8'h0C;
	localparam logic [7:0] EXIT_PL_OFS   = 8'h10;
	localparam logic [7:0] OP_MODE_OFS   = 8'h14;
	localparam logic [7:0] CTRL_WORD_OFS = 8'h18;
	localparam logic [7:0] STAT_WORD_OFS = 8'h1C;
	localparam logic [7:0] DEV_STAT_OFS  = 8'h20;
	localparam logic [7:0] MODES_OFS     = 8'h24;
	localparam logic [7:0] PARAM_OFS     = 8'h28;
	localparam logic [7:0] PARAM_ST_OFS  = 8'h2C;
	// field positions
	localparam int CYC_MOTION_LSB = 8;
	localparam int CYC_FAMILY_BIT = 16;
	localparam int CYC_SMALL_BIT  = 17;
	localparam int SD_DECOUPLE_BIT = 1;
	localparam int PAR_WE_BIT     = 16;
	localparam int PAR_PROT_LSB   = 17;
	localparam int DEV_LEVEL_BIT  = 4;
	// reset values
	localparam logic [7:0]  OP_MODE_RST = 8'h03;
	localparam logic [17:0] CYCLE_RST   = 18'h00101;
	// operation mode codes
	localparam logic [7:0] MODE_VEL      = 8'h02;
	localparam logic [7:0] MODE_POS      = 8'h03;
	localparam logic [7:0] MODE_VEL_NFD  = 8'h0A;
	localparam logic [7:0] MODE_POS_NFD  = 8'h0B;
	localparam logic [7:0] MODE_SYNC_VEL = 8'h42;
	localparam logic [7:0] MODE_SYNC_POS = 8'h43;
	// procedure command handshake values
	localparam logic [1:0] PROC_RUN  = 2'h3;
	localparam logic [1:0] PROC_IDLE = 2'h0;
	// parameter identifier ranges
	localparam logic [11:0] ID_MOTOR_LAST  = 12'h0FF;
	localparam logic [11:0] ID_EXT_LAST    = 12'h1FF;
	localparam logic [11:0] ID_MODULE_BASE = 12'hBB8;
	localparam logic [11:0] ID_MODULE_LAST = 12'hBF7;
	// cycle limits in ms
	localparam logic [5:0] MOTION_MAX_MS = 6'h20;
	// write protection classes
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_OL   = 2'h1;
	localparam logic [1:0] PROT_PL   = 2'h2;
	// communication phase codes CP3 and CP4
	localparam logic [2:0] CP3 = 3'h3;
	localparam logic [2:0] CP4 = 3'h4;

	typedef enum logic [1:0] {TGT_NONE, TGT_MOTOR, TGT_MODULE} target_t;
	// native register access issued towards the motor or module
	typedef struct packed {
		logic      we;
		target_t   target;
		logic [8:0] addr;
	} param_req_t;
endpackage

// file: hdl/drive_ctrl.sv
// drive sub-device state, cycle checking, mode decode and parameter mapping behind an AHB-Lite slave
//
// Overview of operation
// R1 - identifiers 1..255 reach motor registers of the same number over the service channel
// R2 - identifiers 256..511 reach extended motor registers of the same number
// R3 - identifier 3000+n reaches module register n, n from 1 to 63
// R4 - bus cycle must be 1 or 2 ms (large family) or 1,2,3,4,6,8,16 ms
// R5 - motion cycle lies in 1..32 ms and is a whole multiple of bus cycle
// R6 - position mode with motion cycle above bus cycle interpolates between command values
// R7 - control timing stays locked to the master's bus cycle
// R8 - unsupported cycle times refuse the advance to phase four
// R9 - master should avoid 8 ms above 1000 rpm and 16 ms above 500 rpm
// R10 - sub-device machine has two states, parameterization and operating level
// R11 - entering parameterization level clears drive status bits 15 and 14
// R12 - parameterization level allows operating-protected writes, rejects parameterization-protected ones
// R13 - operating level enables monitoring and rejects operating-protected writes
// R14 - in operating level device status bit 4 reads zero
// R15 - coupled: phases 0..2 give parameterization level, phases 3..4 operating level
// R16 - control bit 1 decouples the sub-device state from the phase
// R17 - enter and exit procedure commands move between levels regardless of phase; with control bit 1 clear the phase takes the level back one cycle later
// R18 - mode codes 02,03,0A,0B,42,43 decode to the six operation modes
// R19 - operation mode resets to position control, code 3
// R20 - mode and control word read-write; status word and mode list read-only
// R21 - small motor family gets no drive profile
// R22 - procedure runs on writing 3; zero must be written before the next
// R23 - status bits 15-14 encode not ready, ready, powered, enabled
// R24 - unlisted mode codes are rejected and the old mode kept
`timescale 1ns/10ps
module drive_ctrl
	import drive_ctrl_pkg::*;
(
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      clk_en,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic      [31:0]               hrdata,
	output logic                           hreadyout,
	output logic                           hresp,
	input  wire logic                      bus_cycle_pin,
	input  wire logic                      main_power_pin,
	output drive_ctrl_pkg::param_req_t     param_req,
	output logic                           param_req_valid,
	output logic                           ctrl_tick,
	output logic      [5:0]                interp_step,
	output logic                           interp_active,
	output logic                           monitor_en,
	output logic                           parameterization_level
);
	import drive_ctrl_pkg::*;

	typedef enum logic {SD_PL, SD_OL} sub_device_state_t;

	// registers
	logic [2:0]  phase_reg;
	logic [17:0] cycle_reg;
	logic [1:0]  sd_ctrl_reg;
	logic [1:0]  enter_cmd_reg;
	logic [1:0]  exit_cmd_reg;
	logic        enter_armed_reg;
	logic        exit_armed_reg;
	logic [7:0]  op_mode_reg;
	logic [15:0] ctrl_word_reg;
	logic        refused_reg;
	logic [31:0] param_reg;
	logic [2:0]  param_st_reg;
	sub_device_state_t   sub_device_state_reg;
	sub_device_state_t   sd_next;
	logic [7:0]  wr_addr_reg;
	logic        wr_pend_reg;
	logic [2:0]  sync_reg;
	logic [1:0]  power_sync_reg;
	logic [5:0]  step_reg;

	// bus decode
	wire         addr_phase = hsel & htrans[1] & hready;
	wire         wr_en      = wr_pend_reg & clk_en;
	wire [7:0]   rd_ofs     = haddr[7:0];

	// cycle time checks
	// the cycle word is stored in its bus layout with unused bits zero, so a read returns only the written fields
	wire [4:0]   bus_ms     = cycle_reg[4:0];
	wire [5:0]   motion_ms  = cycle_reg[CYC_MOTION_LSB +: 5] == 5'h00 ? MOTION_MAX_MS
	                          : {1'b0, cycle_reg[CYC_MOTION_LSB +: 5]};
	wire         fam_integr = cycle_reg[CYC_FAMILY_BIT];
	wire         fam_small  = cycle_reg[CYC_SMALL_BIT];
	wire         bus_large  = bus_ms == 5'h01 || bus_ms == 5'h02;
	wire         bus_integr = bus_large || bus_ms == 5'h03 || bus_ms == 5'h04
	                          || bus_ms == 5'h06 || bus_ms == 5'h08 || bus_ms == 5'h10;
	wire         bus_ok     = fam_integr ? bus_integr : bus_large; // R4
	wire [5:0]   ratio      = bus_ok ? motion_ms / {1'b0, bus_ms} : 6'h01;
	wire         motion_ok  = bus_ok && (motion_ms % {1'b0, bus_ms}) == 6'h00; // R5
	wire         profile_on = ~fam_small; // R21
	wire         cycles_ok  = bus_ok & motion_ok & profile_on;

	// mode decode
	wire         is_pos     = op_mode_reg == MODE_POS || op_mode_reg == MODE_POS_NFD
	                          || op_mode_reg == MODE_SYNC_POS; // R18
	wire         is_vel     = op_mode_reg == MODE_VEL || op_mode_reg == MODE_VEL_NFD
	                          || op_mode_reg == MODE_SYNC_VEL; // R18
	wire [7:0]   new_mode   = hwdata[7:0];
	wire         mode_legal = new_mode == MODE_VEL || new_mode == MODE_POS || new_mode == MODE_VEL_NFD
	                          || new_mode == MODE_POS_NFD || new_mode == MODE_SYNC_VEL
	                          || new_mode == MODE_SYNC_POS;
	wire [31:0]  modes_word = {MODE_SYNC_POS, MODE_SYNC_VEL, MODE_POS_NFD, MODE_VEL_NFD};

	// procedure command triggers, only from an armed command
	wire         enter_run  = wr_en && wr_addr_reg == ENTER_PL_OFS && hwdata[1:0] == PROC_RUN
	                          && enter_armed_reg && profile_on; // R22
	wire         exit_run   = wr_en && wr_addr_reg == EXIT_PL_OFS && hwdata[1:0] == PROC_RUN
	                          && exit_armed_reg && profile_on; // R22
	wire         phase_wr   = wr_en && wr_addr_reg == PHASE_OFS;
	wire         phase_bad  = hwdata[2:0] == CP4 && phase_reg != CP4 && !cycles_ok; // R8

	// status word: readiness in bits 15-14
	wire [1:0]   ready_code = sub_device_state_reg == SD_PL ? 2'h0
	                          : !power_sync_reg[1] ? 2'h1
	                          : ctrl_word_reg[15] & ctrl_word_reg[14] ? 2'h3 : 2'h2; // R23
	wire [15:0]  stat_word  = {ready_code, 9'h000, ready_code == 2'h3 & ~ctrl_word_reg[13],
	                           ready_code == 2'h3 & ctrl_word_reg[13], 3'h0}; // R11
	wire [31:0]  dev_status = {26'h0, profile_on, sub_device_state_reg == SD_PL,
	                           refused_reg, interp_active, is_vel, cycles_ok}; // R14

	// parameter identifier mapping
	wire         par_go     = wr_en && wr_addr_reg == PARAM_OFS;
	wire         par_we     = hwdata[PAR_WE_BIT];
	wire [11:0]  go_id      = hwdata[11:0];
	wire [1:0]   go_prot    = hwdata[PAR_PROT_LSB +: 2];
	wire         go_motor   = go_id != 12'h000 && go_id <= ID_EXT_LAST; // R1 R2
	wire         go_module  = go_id > ID_MODULE_BASE && go_id <= ID_MODULE_LAST; // R3
	wire [11:0]  go_index   = go_id - ID_MODULE_BASE;
	wire         go_block   = par_we && ((go_prot == PROT_OL && sub_device_state_reg == SD_OL)
	                          || (go_prot == PROT_PL && sub_device_state_reg == SD_PL)); // R12 R13
	wire         go_ok      = (go_motor | go_module) & ~go_block;

	// read mux
	logic [31:0] rd_data;
	always_comb begin
		case (rd_ofs)
			PHASE_OFS:     rd_data = {29'h0, phase_reg};
			CYCLE_OFS:     rd_data = {14'h0, cycle_reg};
			SD_CTRL_OFS:   rd_data = {30'h0, sd_ctrl_reg};
			ENTER_PL_OFS:  rd_data = {30'h0, enter_cmd_reg};
			EXIT_PL_OFS:   rd_data = {30'h0, exit_cmd_reg};
			OP_MODE_OFS:   rd_data = {24'h0, op_mode_reg};
			CTRL_WORD_OFS: rd_data = {16'h0, ctrl_word_reg};
			STAT_WORD_OFS: rd_data = {16'h0, stat_word}; // R20
			DEV_STAT_OFS:  rd_data = dev_status;
			MODES_OFS:     rd_data = modes_word; // R20
			PARAM_OFS:     rd_data = param_reg;
			PARAM_ST_OFS:  rd_data = {29'h0, param_st_reg};
			default:       rd_data = 32'h0;
		endcase
	end

	// sub-device level: coupled to phase unless decoupled
	always_comb begin
		sd_next = sub_device_state_reg;
		if (enter_run)
			sd_next = SD_PL; // R17
		else if (exit_run)
			sd_next = SD_OL; // R17
		else if (!sd_ctrl_reg[SD_DECOUPLE_BIT]) // R16
			sd_next = phase_reg >= CP3 ? SD_OL : SD_PL; // R15
	end

	// bus address phase and read data; zero wait state, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h0;
			hreadyout   <= 1'b0;
			hresp       <= 1'b0;
		end else if (clk_en) begin
			hreadyout   <= 1'b1;
			wr_pend_reg <= addr_phase & hwrite;
			wr_addr_reg <= {haddr[7:2], 2'h0};
			if (addr_phase && !hwrite)
				hrdata <= rd_data;
		end
	end

	// software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg     <= 3'h0;
			cycle_reg     <= CYCLE_RST;
			sd_ctrl_reg   <= 2'h0;
			op_mode_reg   <= OP_MODE_RST; // R19
			ctrl_word_reg <= 16'h0;
			refused_reg   <= 1'b0;
			param_reg     <= 32'h0;
		end else if (wr_en) begin
			case (wr_addr_reg)
				PHASE_OFS: begin
					refused_reg <= phase_bad; // R8
					if (!phase_bad && hwdata[2:0] <= CP4)
						phase_reg <= hwdata[2:0];
				end
				CYCLE_OFS:     cycle_reg <= {hwdata[CYC_SMALL_BIT], hwdata[CYC_FAMILY_BIT], 3'h0,
				                             hwdata[CYC_MOTION_LSB +: 5], 3'h0, hwdata[4:0]};
				SD_CTRL_OFS:   sd_ctrl_reg <= hwdata[1:0];
				OP_MODE_OFS: begin
					if (mode_legal)
						op_mode_reg <= new_mode; // R24
				end
				CTRL_WORD_OFS: ctrl_word_reg <= hwdata[15:0]; // R20
				PARAM_OFS:     param_reg <= hwdata;
				default:       ;
			endcase
		end
	end

	// procedure command handshake: after a run, a zero must be written before the next
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enter_cmd_reg   <= PROC_IDLE;
			exit_cmd_reg    <= PROC_IDLE;
			enter_armed_reg <= 1'b1;
			exit_armed_reg  <= 1'b1;
		end else if (wr_en) begin
			if (wr_addr_reg == ENTER_PL_OFS) begin
				enter_cmd_reg   <= hwdata[1:0];
				enter_armed_reg <= hwdata[1:0] == PROC_IDLE ? 1'b1 : enter_armed_reg & ~enter_run; // R22
			end
			if (wr_addr_reg == EXIT_PL_OFS) begin
				exit_cmd_reg   <= hwdata[1:0];
				exit_armed_reg <= hwdata[1:0] == PROC_IDLE ? 1'b1 : exit_armed_reg & ~exit_run; // R22
			end
		end
	end

	// level state machine and its outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sub_device_state_reg           <= SD_PL;
			parameterization_level <= 1'b1;
			monitor_en             <= 1'b0;
		end else if (clk_en) begin
			sub_device_state_reg           <= sd_next; // R10
			parameterization_level <= sd_next == SD_PL;
			monitor_en             <= sd_next == SD_OL; // R13
		end
	end

	// parameter access towards native registers, one pulse per accepted request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			param_req       <= '0;
			param_req_valid <= 1'b0;
			param_st_reg    <= 3'h0;
		end else if (clk_en) begin
			param_req_valid <= par_go & go_ok;
			if (par_go) begin
				param_st_reg <= {~go_ok, go_ok, go_block};
				param_req.we <= par_we;
				param_req.target <= go_module ? TGT_MODULE : go_motor ? TGT_MOTOR : TGT_NONE;
				param_req.addr <= go_module ? go_index[8:0] : go_id[8:0]; // R1 R2 R3
			end
		end
	end

	// bus cycle pin: two-stage sync, third stage for the edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_reg       <= 3'h0;
			power_sync_reg <= 2'h0;
		end else if (clk_en) begin
			sync_reg       <= {sync_reg[1:0], bus_cycle_pin};
			power_sync_reg <= {power_sync_reg[0], main_power_pin};
		end
	end

	// control tick per bus cycle; interpolation step within a motion cycle
	wire         cyc_edge  = sync_reg[1] & ~sync_reg[2];
	wire         interp_on = is_pos & (motion_ms > {1'b0, bus_ms}) & cycles_ok; // R6
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_tick     <= 1'b0;
			step_reg      <= 6'h00;
			interp_step   <= 6'h00;
			interp_active <= 1'b0;
		end else if (clk_en) begin
			ctrl_tick     <= cyc_edge; // R7
			interp_active <= interp_on;
			if (cyc_edge) begin
				step_reg    <= (step_reg + 6'h01 >= ratio || !interp_on) ? 6'h00 : step_reg + 6'h01; // R6
				interp_step <= step_reg;
			end
		end
	end

	// checks
	a_level_coupled: assert property (@(posedge hclk) disable iff (!hresetn) // R15
		clk_en && !sd_ctrl_reg[SD_DECOUPLE_BIT] && !enter_run && !exit_run
		|=> (sub_device_state_reg == SD_OL) == ($past(phase_reg) >= CP3))
		else $error("coupled level does not follow phase");
	a_status_pl_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R11
		clk_en && addr_phase && !hwrite && rd_ofs == STAT_WORD_OFS && sub_device_state_reg == SD_PL |=> hrdata[15:14] == 2'h0)
		else $error("status readiness not zero in parameterization level");
	a_dev_level_bit: assert property (@(posedge hclk) disable iff (!hresetn) // R14
		clk_en && addr_phase && !hwrite && rd_ofs == DEV_STAT_OFS && sub_device_state_reg == SD_OL |=> !hrdata[DEV_LEVEL_BIT])
		else $error("device level bit set in operating level");
	a_mode_keep: assert property (@(posedge hclk) disable iff (!hresetn) // R24
		wr_en && wr_addr_reg == OP_MODE_OFS && !mode_legal |=> $stable(op_mode_reg))
		else $error("illegal mode code changed the mode");
	a_cp4_refused: assert property (@(posedge hclk) disable iff (!hresetn) // R8
		phase_wr && phase_bad |=> phase_reg != CP4 && refused_reg)
		else $error("advance to phase four not refused");
	a_proc_rearm: assert property (@(posedge hclk) disable iff (!hresetn) // R22
		enter_run |=> !enter_armed_reg)
		else $error("procedure command runs twice without zero");
	a_module_map: assert property (@(posedge hclk) disable iff (!hresetn) // R3
		clk_en && par_go && go_ok && go_module |=> param_req_valid ##0
		param_req.target == TGT_MODULE && param_req.addr == $past(go_index[8:0]))
		else $error("module identifier mapped wrongly");
	a_motor_map: assert property (@(posedge hclk) disable iff (!hresetn) // R1
		clk_en && par_go && go_ok && go_motor |=> param_req.addr == $past(go_id[8:0]))
		else $error("motor identifier mapped wrongly");
	a_ol_protect: assert property (@(posedge hclk) disable iff (!hresetn) // R13
		clk_en && par_go && par_we && go_prot == PROT_OL && sub_device_state_reg == SD_OL |=> !param_req_valid)
		else $error("operating-protected write accepted");
	a_tick_sync: assert property (@(posedge hclk) disable iff (!hresetn) // R7
		clk_en && $rose(sync_reg[1]) |=> ctrl_tick)
		else $error("control tick missed a bus cycle");
	c_enter_pl: cover property (@(posedge hclk) disable iff (!hresetn) enter_run);
	c_exit_pl: cover property (@(posedge hclk) disable iff (!hresetn) exit_run);
	c_refuse: cover property (@(posedge hclk) disable iff (!hresetn) phase_wr && phase_bad);
	a_pl_accept: assert property (@(posedge hclk) disable iff (!hresetn) // R12
		clk_en && par_go && par_we && go_prot == PROT_OL && go_motor && sub_device_state_reg == SD_PL |=> param_req_valid)
		else $error("operating-protected write refused in parameterization level");
	a_enter_level: assert property (@(posedge hclk) disable iff (!hresetn) // R17
		enter_run |=> sub_device_state_reg == SD_PL && parameterization_level)
		else $error("enter command did not reach parameterization level");
	c_interp: cover property (@(posedge hclk) disable iff (!hresetn) interp_active && ctrl_tick);
	c_cp4_ok: cover property (@(posedge hclk) disable iff (!hresetn) phase_wr && hwdata[2:0] == CP4 && !phase_bad);
endmodule

// file: dv/bus_master_model.sv
// master-side model: bus cycle sync pulses, main power level and capture of native accesses
`timescale 1ns/10ps
module bus_master_model
	import drive_ctrl_pkg::*;
(
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       run_sync,
	input  wire logic                       power_on,
	input  wire drive_ctrl_pkg::param_req_t param_req,
	input  wire logic                       param_req_valid,
	input  wire logic                       ctrl_tick,
	output logic                            bus_cycle_pin,
	output logic                            main_power_pin,
	output drive_ctrl_pkg::param_req_t      last_req,
	output logic [7:0]                      req_count,
	output logic [7:0]                      tick_count
);
	logic [7:0] phase_cnt;

	// sync pulse two cycles wide every 20 cycles; pin rests low outside frames
	assign bus_cycle_pin  = run_sync && (phase_cnt < 8'h02);
	assign main_power_pin = power_on;

	// one fixed cycle length stands for a supported bus cycle; speed advice is left to the user
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_cnt  <= 8'h00;
			req_count  <= 8'h00;
			tick_count <= 8'h00;
			last_req   <= '0;
		end else begin
			phase_cnt  <= (!run_sync || phase_cnt == 8'h13) ? 8'h00 : phase_cnt + 8'h01;
			tick_count <= tick_count + {7'h00, ctrl_tick};
			if (param_req_valid) begin
				last_req  <= param_req;
				req_count <= req_count + 8'h01;
			end
		end
	end
endmodule

// file: dv/testbench.sv
// self-checking bench: register sequences over AHB-Lite against the drive control block
`timescale 1ns/10ps
module testbench;
	import drive_ctrl_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, run_sync, power_on, clk_en;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, bus_cycle_pin, main_power_pin, param_req_valid, ctrl_tick;
	logic        interp_active, monitor_en, parameterization_level;
	logic [5:0]  interp_step;
	logic [7:0]  req_count, tick_count, t0;
	param_req_t  param_req, last_req;
	int          errors, check_count;
	logic [31:0] bad_cyc [3] = '{32'h00010A05, 32'h00010302, 32'h00000603};
	logic [7:0]  codes [6] = '{MODE_VEL, MODE_VEL_NFD, MODE_POS_NFD, MODE_SYNC_VEL, MODE_SYNC_POS, MODE_POS};

	drive_ctrl u_drive_ctrl (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_cycle_pin(bus_cycle_pin),
		.main_power_pin(main_power_pin), .param_req(param_req), .param_req_valid(param_req_valid),
		.ctrl_tick(ctrl_tick), .interp_step(interp_step), .interp_active(interp_active),
		.monitor_en(monitor_en), .parameterization_level(parameterization_level));

	bus_master_model u_bus_master_model (.hclk(hclk), .hresetn(hresetn), .run_sync(run_sync),
		.power_on(power_on), .param_req(param_req), .param_req_valid(param_req_valid),
		.ctrl_tick(ctrl_tick), .bus_cycle_pin(bus_cycle_pin), .main_power_pin(main_power_pin),
		.last_req(last_req), .req_count(req_count), .tick_count(tick_count));

	// 100 MHz clock
	always #5 hclk = ~hclk;

	task print_verdict;
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// bounded wait for the slave's ready at a rising edge
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
			print_verdict;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		hsize  <= 3'h2;
		wait_ready;
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		wait_ready;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		hsize  <= 3'h2;
		wait_ready;
		htrans <= 2'h0;
		hsel   <= 1'b0;
		wait_ready;
		d = hrdata;
	endtask

	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, rdat);
		chk(rdat & m, e);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// native access through an identifier; checks forwarding and the status flags
	task prm(input logic [11:0] id, input logic [1:0] pr, input logic ok, input target_t tg, input logic [8:0] ad);
		logic [7:0] n0;
		n0 = req_count;
		wr(PARAM_OFS, {13'h0000, pr, 1'b1, 4'h0, id});
		cyc(3);
		chk({24'h000000, req_count - n0}, {31'h00000000, ok});
		if (ok)
			chk({20'h00000, last_req}, {20'h00000, 1'b1, tg, ad});
		rc(PARAM_ST_OFS, 32'h00000006, ok ? 32'h00000002 : 32'h00000004);
	endtask

	task lvl(input logic [7:0] a, input logic [31:0] d, input logic e);
		wr(a, d);
		cyc(3);
		chk({31'h00000000, parameterization_level}, {31'h00000000, e});
	endtask

	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		run_sync = 1'b0;
		power_on = 1'b0;
		errors = 0;
		check_count = 0;
		cyc(2);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({31'h0, parameterization_level}, 32'h1);
		rc(OP_MODE_OFS, 32'h000000FF, 32'h00000003);
		rc(CYCLE_OFS, 32'hFFFFFFFF, 32'h00000101);
		rc(DEV_STAT_OFS, 32'h00000010, 32'h00000010);
		rc(8'h30, 32'hFFFFFFFF, 32'h00000000);
		for (int i = 0; i < 6; i++) begin
			wr(OP_MODE_OFS, {24'h000000, codes[i]});
			rc(OP_MODE_OFS, 32'h000000FF, {24'h000000, codes[i]});
		end
		wr(OP_MODE_OFS, 32'h00000005);
		rc(OP_MODE_OFS, 32'h000000FF, 32'h00000003);
		wr(MODES_OFS, 32'h00000000);
		rc(MODES_OFS, 32'hFFFFFFFF, 32'h43420B0A);
		prm(12'd1, PROT_NONE, 1'b1, TGT_MOTOR, 9'd1);
		prm(12'd255, PROT_NONE, 1'b1, TGT_MOTOR, 9'd255);
		prm(12'd256, PROT_NONE, 1'b1, TGT_MOTOR, 9'd256);
		prm(12'd511, PROT_NONE, 1'b1, TGT_MOTOR, 9'd511);
		prm(12'd3001, PROT_NONE, 1'b1, TGT_MODULE, 9'd1);
		prm(12'd3063, PROT_NONE, 1'b1, TGT_MODULE, 9'd63);
		prm(12'd0, PROT_NONE, 1'b0, TGT_NONE, 9'd0);
		prm(12'd512, PROT_NONE, 1'b0, TGT_NONE, 9'd0);
		prm(12'd3000, PROT_NONE, 1'b0, TGT_NONE, 9'd0);
		prm(12'd3064, PROT_NONE, 1'b0, TGT_NONE, 9'd0);
		lvl(PHASE_OFS, 32'h3, 1'b0);
		chk({31'h0, monitor_en}, 32'h1);
		rc(DEV_STAT_OFS, 32'h00000010, 32'h00000000);
		rc(STAT_WORD_OFS, 32'h0000C000, 32'h00004000);
		prm(12'd5, PROT_OL, 1'b0, TGT_NONE, 9'd0);
		prm(12'd5, PROT_PL, 1'b1, TGT_MOTOR, 9'd5);
		power_on <= 1'b1;
		cyc(8);
		rc(STAT_WORD_OFS, 32'h0000C000, 32'h00008000);
		wr(CTRL_WORD_OFS, 32'h0000C000);
		rc(CTRL_WORD_OFS, 32'h0000FFFF, 32'h0000C000);
		rc(STAT_WORD_OFS, 32'h0000C018, 32'h0000C010);
		for (int i = 0; i < 3; i++) begin
			wr(CYCLE_OFS, bad_cyc[i]);
			wr(PHASE_OFS, 32'h4);
			rc(PHASE_OFS, 32'h00000007, 32'h00000003);
			rc(DEV_STAT_OFS, 32'h00000008, 32'h00000008);
		end
		wr(CYCLE_OFS, 32'h00010802);
		wr(PHASE_OFS, 32'h4);
		rc(PHASE_OFS, 32'h00000007, 32'h00000004);
		rc(DEV_STAT_OFS, 32'h00000029, 32'h00000021);
		chk({31'h0, interp_active}, 32'h1);
		wr(OP_MODE_OFS, {24'h000000, MODE_VEL});
		cyc(3);
		chk({31'h0, interp_active}, 32'h0);
		rc(DEV_STAT_OFS, 32'h00000002, 32'h00000002);
		wr(OP_MODE_OFS, {24'h000000, MODE_POS});
		// three sync pulses in 60 cycles give three ticks; motion spans four bus cycles, so step 2
		t0 = tick_count;
		run_sync <= 1'b1;
		cyc(60);
		run_sync <= 1'b0;
		cyc(10);
		chk({24'h0, tick_count - t0}, 32'h3);
		chk({26'h0, interp_step}, 32'h2);
		// clock enable low: pulses on the pin must leave no trace
		t0 = tick_count;
		clk_en <= 1'b0;
		run_sync <= 1'b1;
		cyc(40);
		run_sync <= 1'b0;
		cyc(5);
		clk_en <= 1'b1;
		cyc(5);
		chk({24'h0, tick_count - t0}, 32'h0);
		chk({26'h0, interp_step}, 32'h2);
		wr(SD_CTRL_OFS, 32'h2);
		lvl(ENTER_PL_OFS, 32'h3, 1'b1);
		rc(STAT_WORD_OFS, 32'h0000C000, 32'h00000000);
		prm(12'd7, PROT_OL, 1'b1, TGT_MOTOR, 9'd7);
		prm(12'd7, PROT_PL, 1'b0, TGT_NONE, 9'd0);
		lvl(EXIT_PL_OFS, 32'h3, 1'b0);
		lvl(ENTER_PL_OFS, 32'h3, 1'b0);
		lvl(ENTER_PL_OFS, 32'h0, 1'b0);
		lvl(ENTER_PL_OFS, 32'h3, 1'b1);
		lvl(EXIT_PL_OFS, 32'h0, 1'b1);
		lvl(EXIT_PL_OFS, 32'h3, 1'b0);
		wr(CYCLE_OFS, 32'h00030802);
		rc(DEV_STAT_OFS, 32'h00000020, 32'h00000000);
		lvl(ENTER_PL_OFS, 32'h0, 1'b0);
		lvl(ENTER_PL_OFS, 32'h3, 1'b0);
		print_verdict;
	end
endmodule
